// [core/dma_chain.sv]
// Descriptor-chaining DMA engine with shared static RAM and descriptors.
// Assumes peripherals answer PER_REQ with a one-clock PER_ACK after any number of clocks.
// What this block does
// - A descriptor may name itself next, repeating its transfer forever.
// - Two descriptors naming each other alternate, giving double buffering.
// - Longer chains loop from the last descriptor back to the first.
// - A descriptor can fetch a peripheral value into a later descriptor.
// - The successor is loaded as it stands when its predecessor completes.
// - Each descriptor carries its own source and destination addresses.
// - Descriptor storage is memory mapped for the engine and processor.
// - Chains copy memory to peripheral and peripheral status to memory.
// - The engine reads and writes every static RAM location.
// - Processor and engine are served together in different 32 KB blocks.
`timescale 1ns/1ns
module dma_chain
    import dma_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        START,
    input  wire logic [2:0]  START_DESC,
    input  wire logic        STOP,
    output logic             BUSY,
    output logic             DESC_DONE,
    output logic [2:0]       CUR_DESC,
    input  wire logic        CPU_REQ,
    input  wire logic        CPU_WE,
    input  wire logic [31:0] CPU_ADDR,
    input  wire logic [31:0] CPU_WDATA,
    output logic             CPU_ACK,
    output logic [31:0]      CPU_RDATA,
    output logic             PER_REQ,
    output logic             PER_WE,
    output logic [31:0]      PER_ADDR,
    output logic [31:0]      PER_WDATA,
    input  wire logic        PER_ACK,
    input  wire logic [31:0] PER_RDATA
);
    logic [31:0] sram_mem [0:SRAM_WORDS-1];
    logic [31:0] desc_mem [0:DESC_SLOTS-1];
    state_t      state_reg;
    logic [2:0]  cur_desc_reg;
    logic [31:0] src_reg;
    logic [31:0] dst_reg;
    logic [15:0] rem_reg;
    logic [2:0]  next_reg;
    logic        end_reg;
    logic        sinc_reg;
    logic        dinc_reg;
    logic        stop_reg;
    logic        busy_reg;
    logic        done_reg;
    logic        int_ret_reg;
    logic [31:0] int_rdata_reg;
    logic        per_req_reg;
    logic        per_we_reg;
    logic [31:0] per_addr_reg;
    logic [31:0] per_wdata_reg;
    logic        cpu_ack_reg;
    logic [31:0] cpu_rdata_reg;
    logic        last_dma_reg;
    res_t        rd_res;
    res_t        wr_res;
    res_t        cpu_res;
    res_t        dma_res;
    logic [4:0]  load_base;
    logic [31:0] load_src;
    logic [31:0] load_cnt;
    logic [31:0] load_ctrl;
    logic        rd_busy;
    logic        int_wr_want;
    logic        per_wr_launch;
    logic        rd_want;
    logic        dma_req;
    logic        cpu_take;
    logic        conflict;
    logic        cpu_gnt;
    logic        dma_gnt;
    logic        rd_fire_int;
    logic        rd_fire_per;
    logic        rd_fire;
    logic        wr_fire_int;
    logic        pop;
    logic        run_idle;
    logic        follow;

    stream_if buf_if ();

    word_buffer u_buf (
        .CLK  (CLK),
        .NRST (NRST),
        .st   (buf_if.store)
    );

    assign BUSY      = busy_reg;
    assign DESC_DONE = done_reg;
    assign CUR_DESC  = cur_desc_reg;
    assign CPU_ACK   = cpu_ack_reg;
    assign CPU_RDATA = cpu_rdata_reg;
    assign PER_REQ   = per_req_reg;
    assign PER_WE    = per_we_reg;
    assign PER_ADDR  = per_addr_reg;
    assign PER_WDATA = per_wdata_reg;

    // Successor contents read at load time, never cached earlier
    assign load_base = {cur_desc_reg, 2'b00};
    assign load_src  = desc_mem[load_base | {3'b000, W_SRC}];
    assign load_cnt  = desc_mem[load_base | {3'b000, W_CNT}];
    assign load_ctrl = desc_mem[load_base | {3'b000, W_CTRL}];

    // Address decode of the two engine pointers and the processor
    assign rd_res  = res_of(src_reg);
    assign wr_res  = res_of(dst_reg);
    assign cpu_res = res_of(CPU_ADDR);

    // Write side drains the buffer; it has priority on the internal port
    assign int_wr_want   = buf_if.out_valid && wr_res != RES_PER;
    assign per_wr_launch = buf_if.out_valid && wr_res == RES_PER
                           && !per_req_reg;
    assign rd_busy = int_ret_reg || (per_req_reg && !per_we_reg);
    assign rd_want = state_reg == ST_RUN && rem_reg != 16'h0000
                     && !rd_busy && buf_if.in_ready
                     && (rd_res == RES_PER
                         ? (!per_req_reg && !per_wr_launch)
                         : !int_wr_want);

    // Per-block arbitration, winner alternates on contention
    assign dma_req  = int_wr_want || (rd_want && rd_res != RES_PER);
    assign dma_res  = int_wr_want ? wr_res : rd_res;
    assign cpu_take = CPU_REQ && !cpu_ack_reg;
    assign conflict = cpu_take && dma_req && cpu_res == dma_res;
    assign cpu_gnt  = cpu_take && (!conflict || last_dma_reg);
    assign dma_gnt  = dma_req && (!conflict || !last_dma_reg);

    assign rd_fire_int = dma_gnt && !int_wr_want;
    assign rd_fire_per = rd_want && rd_res == RES_PER;
    assign rd_fire     = rd_fire_int || rd_fire_per;
    assign wr_fire_int = int_wr_want && dma_gnt;
    assign pop = wr_fire_int || (per_req_reg && per_we_reg && PER_ACK);

    // Buffer hookup: read data in, destination writes out
    assign buf_if.in_valid  = int_ret_reg
                              || (per_req_reg && !per_we_reg && PER_ACK);
    assign buf_if.in_data   = int_ret_reg ? int_rdata_reg : PER_RDATA;
    assign buf_if.out_ready = pop;

    assign run_idle = rem_reg == 16'h0000 && !rd_busy
                      && !buf_if.out_valid && !per_req_reg;
    assign follow   = !end_reg && !stop_reg && !STOP;

    // Contention history
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            last_dma_reg <= 1'b0;
        end else if (conflict) begin
            last_dma_reg <= dma_gnt;
        end
    end

    // Shared memories: both sides may write in one cycle in distinct blocks
    always_ff @(posedge CLK) begin
        if (cpu_gnt && CPU_WE && cpu_res == RES_DESC) begin
            desc_mem[CPU_ADDR[DESC_IDX_MSB:2]] <= CPU_WDATA;
        end else if (cpu_gnt && CPU_WE && cpu_res != RES_PER) begin
            sram_mem[CPU_ADDR[SRAM_IDX_MSB:2]] <= CPU_WDATA;
        end
        if (wr_fire_int && wr_res == RES_DESC) begin
            desc_mem[dst_reg[DESC_IDX_MSB:2]] <= buf_if.out_data;
        end else if (wr_fire_int) begin
            sram_mem[dst_reg[SRAM_IDX_MSB:2]] <= buf_if.out_data;
        end
    end

    // Processor answer one cycle after its grant
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cpu_ack_reg   <= 1'b0;
            cpu_rdata_reg <= 32'h0000_0000;
        end else begin
            cpu_ack_reg <= cpu_gnt;
            if (cpu_gnt && !CPU_WE) begin
                unique case (cpu_res)
                    RES_DESC: cpu_rdata_reg <=
                        desc_mem[CPU_ADDR[DESC_IDX_MSB:2]];
                    RES_PER:  cpu_rdata_reg <= 32'h0000_0000;
                    default:  cpu_rdata_reg <=
                        sram_mem[CPU_ADDR[SRAM_IDX_MSB:2]];
                endcase
            end
        end
    end

    // Engine internal reads return the next cycle
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            int_ret_reg   <= 1'b0;
            int_rdata_reg <= 32'h0000_0000;
        end else begin
            int_ret_reg <= rd_fire_int;
            if (rd_fire_int) begin
                int_rdata_reg <= (rd_res == RES_DESC)
                    ? desc_mem[src_reg[DESC_IDX_MSB:2]]
                    : sram_mem[src_reg[SRAM_IDX_MSB:2]];
            end
        end
    end

    // Peripheral port: request held until acknowledged
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            per_req_reg   <= 1'b0;
            per_we_reg    <= 1'b0;
            per_addr_reg  <= 32'h0000_0000;
            per_wdata_reg <= 32'h0000_0000;
        end else if (per_req_reg) begin
            per_req_reg <= !PER_ACK;
        end else if (per_wr_launch) begin
            per_req_reg   <= 1'b1;
            per_we_reg    <= 1'b1;
            per_addr_reg  <= dst_reg;
            per_wdata_reg <= buf_if.out_data;
        end else if (rd_fire_per) begin
            per_req_reg  <= 1'b1;
            per_we_reg   <= 1'b0;
            per_addr_reg <= src_reg;
        end
    end

    // Working copy of the active descriptor
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            src_reg  <= 32'h0000_0000;
            dst_reg  <= 32'h0000_0000;
            rem_reg  <= 16'h0000;
            next_reg <= 3'h0;
            end_reg  <= 1'b0;
            sinc_reg <= 1'b0;
            dinc_reg <= 1'b0;
        end else if (state_reg == ST_LOAD) begin
            src_reg  <= load_src;
            dst_reg  <= desc_mem[load_base | {3'b000, W_DST}];
            rem_reg  <= load_cnt[COUNT_W-1:0];
            next_reg <= load_ctrl[CTRL_NEXT_LSB +: DESC_IDX_W];
            end_reg  <= load_ctrl[CTRL_END_BIT];
            sinc_reg <= load_ctrl[CTRL_SINC_BIT];
            dinc_reg <= load_ctrl[CTRL_DINC_BIT];
        end else begin
            if (rd_fire) begin
                src_reg <= sinc_reg ? src_reg + WORD_STEP : src_reg;
                rem_reg <= rem_reg - 16'h0001;
            end
            if (pop && dinc_reg) begin
                dst_reg <= dst_reg + WORD_STEP;
            end
        end
    end

    // Stop request, held until the next START from idle; set wins over clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            stop_reg <= 1'b0;
        end else if (STOP) begin
            stop_reg <= 1'b1;
        end else if (state_reg == ST_IDLE && START) begin
            stop_reg <= 1'b0;
        end
    end

    // Chain sequencer
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state_reg    <= ST_IDLE;
            cur_desc_reg <= 3'h0;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: if (START) begin
                    cur_desc_reg <= START_DESC;
                    busy_reg     <= 1'b1;
                    state_reg    <= ST_LOAD;
                end
                ST_LOAD: state_reg <= ST_RUN;
                ST_RUN: if (run_idle) begin
                    done_reg  <= 1'b1;
                    state_reg <= ST_NEXT;
                end
                ST_NEXT: if (follow) begin
                    cur_desc_reg <= next_reg;
                    state_reg    <= ST_LOAD;
                end else begin
                    busy_reg  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    property p_self_chain;
        @(posedge CLK) disable iff (!NRST)
        state_reg == ST_NEXT && follow && next_reg == cur_desc_reg
        |=> state_reg == ST_LOAD && $stable(cur_desc_reg);
    endproperty
    a_self_chain: assert property (p_self_chain)
        else $error("self-chained descriptor not repeated");

    property p_follow_next;
        @(posedge CLK) disable iff (!NRST)
        state_reg == ST_NEXT && follow
        |=> cur_desc_reg == $past(next_reg) ##1 state_reg == ST_RUN;
    endproperty
    a_follow_next: assert property (p_follow_next)
        else $error("successor not taken after completion");

    property p_loop_back;
        @(posedge CLK) disable iff (!NRST)
        state_reg == ST_NEXT && follow && next_reg < cur_desc_reg
        |=> state_reg == ST_LOAD && cur_desc_reg < $past(cur_desc_reg);
    endproperty
    a_loop_back: assert property (p_loop_back)
        else $error("chain did not loop back");

    property p_desc_rewrite;
        @(posedge CLK) disable iff (!NRST)
        wr_fire_int && wr_res == RES_DESC
        |=> desc_mem[$past(dst_reg[DESC_IDX_MSB:2])]
            == $past(buf_if.out_data);
    endproperty
    a_desc_rewrite: assert property (p_desc_rewrite)
        else $error("descriptor word not rewritten");

    property p_load_fresh;
        @(posedge CLK) disable iff (!NRST)
        state_reg == ST_LOAD
        |=> src_reg == $past(load_src)
            && rem_reg == $past(load_cnt[COUNT_W-1:0]);
    endproperty
    a_load_fresh: assert property (p_load_fresh)
        else $error("descriptor not loaded as it stood");

    property p_src_step;
        @(posedge CLK) disable iff (!NRST)
        state_reg == ST_RUN && rd_fire && sinc_reg
        |=> src_reg == $past(src_reg) + WORD_STEP;
    endproperty
    a_src_step: assert property (p_src_step)
        else $error("source pointer did not advance");

    property p_cpu_desc;
        @(posedge CLK) disable iff (!NRST)
        cpu_gnt && CPU_WE && cpu_res == RES_DESC
        |=> CPU_ACK && desc_mem[$past(CPU_ADDR[DESC_IDX_MSB:2])]
            == $past(CPU_WDATA);
    endproperty
    a_cpu_desc: assert property (p_cpu_desc)
        else $error("processor descriptor write lost");

    property p_per_hold;
        @(posedge CLK) disable iff (!NRST)
        PER_REQ && !PER_ACK
        |=> PER_REQ && $stable(PER_ADDR) && $stable(PER_WE);
    endproperty
    a_per_hold: assert property (p_per_hold)
        else $error("peripheral request dropped before ack");

    property p_sram_read;
        @(posedge CLK) disable iff (!NRST)
        rd_fire_int && rd_res != RES_DESC
        |=> buf_if.in_valid
            && buf_if.in_data == $past(sram_mem[src_reg[SRAM_IDX_MSB:2]]);
    endproperty
    a_sram_read: assert property (p_sram_read)
        else $error("engine read of static RAM wrong");

    property p_parallel;
        @(posedge CLK) disable iff (!NRST)
        cpu_take && dma_req && cpu_res != dma_res
        |-> dma_gnt ##1 CPU_ACK;
    endproperty
    a_parallel: assert property (p_parallel)
        else $error("different blocks not served together");

    property p_contend;
        @(posedge CLK) disable iff (!NRST)
        conflict && !cpu_gnt |-> dma_gnt ##1 (!cpu_take || cpu_gnt);
    endproperty
    a_contend: assert property (p_contend)
        else $error("contention loser not served next cycle");

    c_self: cover property (@(posedge CLK) disable iff (!NRST)
        state_reg == ST_NEXT && follow && next_reg == cur_desc_reg);
    c_conflict: cover property (@(posedge CLK) disable iff (!NRST)
        conflict);
    c_full: cover property (@(posedge CLK) disable iff (!NRST)
        !buf_if.in_ready && PER_REQ && PER_WE);
    c_fetch: cover property (@(posedge CLK) disable iff (!NRST)
        wr_fire_int && wr_res == RES_DESC);
endmodule

// [core/word_buffer.sv]
// Two-entry word buffer with valid and ready on both sides.
// Assumes synchronous active-low reset on the engine clock.
`timescale 1ns/1ns
module word_buffer
    import dma_pkg::*;
(
    input  wire logic CLK,
    input  wire logic NRST,
    stream_if.store   st
);
    logic [31:0] mem [0:BUF_DEPTH-1];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  cnt_reg;
    logic        push;
    logic        pop;

    // Full and empty come from the occupancy count
    assign st.in_ready  = (cnt_reg != 2'h2);
    assign st.out_valid = (cnt_reg != 2'h0);
    assign st.out_data  = mem[rd_ptr_reg];
    assign push = st.in_valid && st.in_ready;
    assign pop  = st.out_ready && st.out_valid;

    // Storage, written only on an accepted word
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr_reg] <= st.in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// [include/dma_pkg.sv]
// Constants, types and address decode shared by the chaining engine.
// Assumes one 10 MHz clock and a flat 32-bit byte address space.
package dma_pkg;
    localparam int          DATA_W        = 32;
    localparam int          COUNT_W       = 16;
    localparam int          DESC_NUM      = 8;
    localparam int          DESC_IDX_W    = 3;
    localparam int          BUF_DEPTH     = 2;
    // Static RAM: 64 KB in two 32 KB blocks, block chosen by addr[15]
    localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
    localparam logic [31:0] SRAM_BYTES    = 32'h0001_0000;
    localparam int          SRAM_WORDS    = 16384;
    localparam int          BLOCK_BIT     = 15;
    localparam int          SRAM_IDX_MSB  = 15;
    // Descriptor space: 8 descriptors of 4 words each
    localparam logic [31:0] DESC_BASE     = 32'h4000_4000;
    localparam logic [31:0] DESC_BYTES    = 32'h0000_0080;
    localparam int          DESC_SLOTS    = 32;
    localparam int          DESC_IDX_MSB  = 6;
    localparam logic [1:0]  W_SRC         = 2'h0;
    localparam logic [1:0]  W_DST         = 2'h1;
    localparam logic [1:0]  W_CNT         = 2'h2;
    localparam logic [1:0]  W_CTRL        = 2'h3;
    // Control word fields
    localparam int          CTRL_NEXT_LSB = 0;
    localparam int          CTRL_END_BIT  = 8;
    localparam int          CTRL_SINC_BIT = 9;
    localparam int          CTRL_DINC_BIT = 10;
    localparam logic [31:0] WORD_STEP     = 32'h0000_0004;

    // Resources that can be claimed in one cycle
    typedef enum logic [1:0] {RES_LO, RES_HI, RES_DESC, RES_PER} res_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_NEXT} state_t;

    function automatic res_t res_of(input logic [31:0] a);
        res_t r;
        r = RES_PER;
        if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES) begin
            r = a[BLOCK_BIT] ? RES_HI : RES_LO;
        end else if (a >= DESC_BASE && a < DESC_BASE + DESC_BYTES) begin
            r = RES_DESC;
        end
        return r;
    endfunction
endpackage

// [include/stream_if.sv]
// Word stream between the read side and the write side of the engine.
// Assumes producer and consumer share the engine clock.
`timescale 1ns/1ns
interface stream_if;
    logic        in_valid;
    logic        in_ready;
    logic [31:0] in_data;
    logic        out_valid;
    logic        out_ready;
    logic [31:0] out_data;
    modport fill  (output in_valid, in_data, out_ready,
                   input  in_ready, out_valid, out_data);
    modport store (input  in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
endinterface

// [testbench/per_model.sv]
// Peripheral-bus model: sixteen word registers behind a request/ack bus.
// Assumes the engine holds PER_REQ and its fields until PER_ACK.
`timescale 1ns/1ns
module per_model (
    input  wire logic        CLK,
    input  wire logic [3:0]  DELAY,
    input  wire logic        PER_REQ,
    input  wire logic        PER_WE,
    input  wire logic [31:0] PER_ADDR,
    input  wire logic [31:0] PER_WDATA,
    output logic             PER_ACK,
    output logic [31:0]      PER_RDATA
);
    logic [31:0] regs [0:15];
    logic [3:0]  wait_cnt;

    initial {PER_ACK, PER_RDATA, wait_cnt} = '0;

    // Answer a held request after DELAY waiting cycles
    always @(posedge CLK) begin
        if (PER_REQ && !PER_ACK && wait_cnt >= DELAY) begin
            PER_ACK <= 1'b1;
            PER_RDATA <= PER_WE ? ~PER_RDATA : regs[PER_ADDR[5:2]];
            if (PER_WE) regs[PER_ADDR[5:2]] <= PER_WDATA;
            wait_cnt <= 4'h0;
        end else begin
            PER_ACK <= 1'b0;
            PER_RDATA <= ~PER_RDATA; // Released data lines keep toggling
            wait_cnt <= (PER_REQ && !PER_ACK) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the descriptor-chaining engine.
// Assumes the peripheral model answers at 0x5000_0000 upwards.
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module testbench
    import dma_pkg::*;
;
    logic        CLK, NRST, START, STOP, BUSY, DESC_DONE;
    logic        CPU_REQ, CPU_WE, CPU_ACK, PER_REQ, PER_WE, PER_ACK;
    logic [2:0]  START_DESC, CUR_DESC;
    logic [31:0] CPU_ADDR, CPU_WDATA, CPU_RDATA, rdata;
    logic [31:0] PER_ADDR, PER_WDATA, PER_RDATA;
    logic [3:0]  per_delay;
    int          failures, n_checks, lat, done;

    dma_chain uut (.CLK(CLK), .NRST(NRST), .START(START),
        .START_DESC(START_DESC), .STOP(STOP), .BUSY(BUSY),
        .DESC_DONE(DESC_DONE), .CUR_DESC(CUR_DESC), .CPU_REQ(CPU_REQ),
        .CPU_WE(CPU_WE), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
        .CPU_ACK(CPU_ACK), .CPU_RDATA(CPU_RDATA), .PER_REQ(PER_REQ),
        .PER_WE(PER_WE), .PER_ADDR(PER_ADDR), .PER_WDATA(PER_WDATA),
        .PER_ACK(PER_ACK), .PER_RDATA(PER_RDATA));

    per_model per (.CLK(CLK), .DELAY(per_delay), .PER_REQ(PER_REQ),
        .PER_WE(PER_WE), .PER_ADDR(PER_ADDR), .PER_WDATA(PER_WDATA),
        .PER_ACK(PER_ACK), .PER_RDATA(PER_RDATA));

    // 10 MHz clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A wait that ran out counts as a mismatch
    task automatic give_up();
        failures++;
        tally_and_finish();
    endtask

    // One processor access held until acked; lat is 2 when unstalled
    task automatic cpu(input logic we, input logic [31:0] a, d);
        @(posedge CLK);
        CPU_REQ <= 1'b1;
        CPU_WE <= we;
        CPU_ADDR <= a;
        CPU_WDATA <= d;
        lat = 0;
        do begin
            @(posedge CLK);
            lat++;
        end while (CPU_ACK !== 1'b1 && lat < 20);
        rdata = CPU_RDATA;
        CPU_REQ <= 1'b0;
        if (lat >= 20) give_up();
    endtask

    // Control word from next index, end, source and destination steps
    function automatic logic [31:0] ctl(input int nx, e, si, di);
        return 32'(nx) | 32'(e) << CTRL_END_BIT | 32'(si) << CTRL_SINC_BIT
               | 32'(di) << CTRL_DINC_BIT;
    endfunction

    // Write all four words of one descriptor
    task automatic desc(input int n, input logic [31:0] s, t, c, k);
        logic [31:0] w [4];
        w = '{s, t, c, k};
        for (int i = 0; i < 4; i++) begin
            cpu(1'b1, DESC_BASE + 32'(16 * n + 4 * i), w[i]);
        end
    endtask

    // Pulse START for one cycle
    task automatic start_chain(input logic [2:0] first);
        @(posedge CLK);
        START <= 1'b1;
        START_DESC <= first;
        @(posedge CLK);
        START <= 1'b0;
    endtask

    // Wait for the chain to stop, counting completed descriptors
    task automatic wait_idle();
        int n;
        n = 0;
        done = 0;
        do begin
            @(posedge CLK);
            n++;
            if (DESC_DONE === 1'b1) done++;
        end while (BUSY !== 1'b0 && n < 3000);
        if (n >= 3000) give_up();
    endtask

    // Gather words from both blocks into a slow peripheral
    task automatic t_gather();
        per_delay <= 4'h3;
        cpu(1'b1, 32'h2000_0000, 32'h1111_0000);
        cpu(1'b1, 32'h2000_0004, 32'h2222_0000);
        cpu(1'b1, 32'h2000_fffc, 32'h3333_0000);
        desc(0, 32'h2000_0000, 32'h5000_0000, 2, ctl(1, 0, 1, 1));
        desc(1, 32'h2000_fffc, 32'h5000_0008, 1, ctl(0, 1, 0, 0));
        start_chain(3'h0);
        wait_idle();
        `CHK(done, 32'h2)
        `CHK(per.regs[1], 32'h2222_0000)
        `CHK(per.regs[2], 32'h3333_0000)
        $display("test gather done");
    endtask

    // Config out, address fetch into a later descriptor, status back
    task automatic t_fetch();
        per.regs[4] = 32'h2000_8010;
        per.regs[9] = 32'h0000_00c3;
        per_delay <= 4'h0;
        cpu(1'b1, 32'h2000_8010, 32'h5a5a_0001);
        desc(0, 32'h2000_0000, 32'h5000_0028, 1, ctl(2, 0, 0, 0));
        desc(2, 32'h5000_0010, DESC_BASE + 32'h30, 1, ctl(3, 0, 0, 0));
        desc(3, 32'h2000_0000, 32'h2000_0100, 1, ctl(1, 0, 0, 0));
        desc(1, 32'h5000_0024, 32'h2000_0200, 1, ctl(0, 1, 0, 0));
        start_chain(3'h0);
        wait_idle();
        `CHK(done, 32'h4)
        `CHK(per.regs[10], 32'h1111_0000)
        cpu(1'b0, DESC_BASE + 32'h30, 32'h0);
        `CHK(rdata, 32'h2000_8010)
        cpu(1'b0, 32'h2000_0100, 32'h0);
        `CHK(rdata, 32'h5a5a_0001)
        cpu(1'b0, 32'h2000_0200, 32'h0);
        `CHK(rdata, 32'h0000_00c3)
        $display("test fetch done");
    endtask

    // Engine fills block 1 while the processor works in both blocks
    task automatic t_contend();
        per.regs[12] = 32'h0bad_cafe;
        desc(7, 32'h5000_0030, 32'h2000_8040, 8, ctl(0, 1, 0, 1));
        start_chain(3'h7);
        repeat (3) begin
            cpu(1'b0, 32'h2000_0004, 32'h0);
            `CHK(lat, 2)
            cpu(1'b1, 32'h2000_8100, 32'h00c0_ffee);
            `CHK(lat inside {2, 3}, 1'b1)
        end
        wait_idle();
        cpu(1'b0, 32'h2000_805c, 32'h0);
        `CHK(rdata, 32'h0bad_cafe)
        cpu(1'b0, 32'h2000_8100, 32'h0);
        `CHK(rdata, 32'h00c0_ffee)
        $display("test contend done");
    endtask

    // Follow a looping chain, try a restart while busy, then stop it
    task automatic t_loop(input logic [2:0] base, input int period);
        logic [2:0] prev;
        logic [2:0] exp;
        int         seen, n;
        seen = 0;
        n = 0;
        prev = base;
        start_chain(base);
        while (seen < 6 && n < 600) begin
            @(posedge CLK);
            n++;
            START <= (n == 3);
            START_DESC <= 3'h7;
            if (DESC_DONE === 1'b1) begin
                exp = 3'(int'(base) + (int'(prev) - int'(base) + 1) % period);
                if (seen > 0) `CHK(CUR_DESC, exp)
                prev = CUR_DESC;
                seen++;
            end
        end
        if (n >= 600) give_up();
        STOP <= 1'b1;
        @(posedge CLK);
        STOP <= 1'b0;
        wait_idle();
        $display("test loop done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        {NRST, START, STOP, CPU_REQ, CPU_WE, START_DESC} = '0;
        {CPU_ADDR, CPU_WDATA, per_delay} = '0;
        {failures, n_checks} = '0;
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        t_gather();
        t_fetch();
        t_contend();
        desc(4, 32'h2000_0004, 32'h5000_0020, 1, ctl(4, 0, 0, 0));
        t_loop(3'h4, 1);
        `CHK(per.regs[8], 32'h2222_0000)
        desc(5, 32'h2000_0000, 32'h2000_8080, 1, ctl(6, 0, 0, 0));
        desc(6, 32'h2000_8080, 32'h2000_0080, 1, ctl(5, 0, 0, 0));
        t_loop(3'h5, 2);
        cpu(1'b0, 32'h2000_0080, 32'h0);
        `CHK(rdata, 32'h1111_0000)
        for (int i = 0; i < 3; i++) begin
            desc(i, 32'h2000_0000, 32'h5000_0034, 1,
                 ctl((i + 1) % 3, 0, 0, 0));
        end
        t_loop(3'h0, 3);
        tally_and_finish();
    end
endmodule
